// ### msa_top.sv
// Status flags, alert mask, watchdog pins, shunt result and serial register port
`timescale 1ns/10ps
module msa_top #(
    parameter logic [6:0] DEV_ADDR = 7'h40
) (
    input wire logic clk, // 125 MHz clock
    input wire logic rst_n, // Async reset, active low
    input wire logic scl_i, // Serial clock pin
    input wire logic sda_i, // Serial data pin level
    output logic sda_o, // Serial data drive value
    output logic sda_oe, // Serial data drive enable
    output logic alert_o, // Alert pin drive value
    output logic alert_oe, // Alert pin drive enable
    output logic warning_pin, // Warning watchdog output
    output logic limit_pin, // Over-limit watchdog output
    output logic critical_pin, // Critical comparator output
    input wire msa_pkg::msa_meas_t meas, // Latest results
    input wire logic meas_done, // Pulse: results of a cycle ready
    input wire logic math_ovf, // Pulse: arithmetic overflow
    input wire msa_pkg::msa_limits_t limits, // Limit register values
    input wire msa_pkg::msa_latch_t latch_opt, // Flag latch options
    input wire logic [1:0] shunt_gain_select, // Gain code from config
    input wire logic cfg_write, // Pulse: config register written
    input wire logic [2:0] cfg_mode, // Mode field of that write
    input wire logic convert_trig, // Pulse: single-shot from convert pin
    output logic [15:0] alert_mask_enable, // Mask/enable register
    output logic [15:0] shunt_voltage_result, // Formatted shunt result
    output logic [15:0] limit_status_flags // Status register
);
    // Address must fit the 7-bit field and not be a reserved all-zero call
    generate
        if (DEV_ADDR == 7'h00)
        begin : g_bad_addr
            $error("DEV_ADDR must not be zero");
        end
    endgenerate

    // Pin synchronisers: first stage feeds only the second
    logic scl_m_r, sda_m_r, scl_s_r, sda_s_r, scl_d_r, sda_d_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_m_r <= 1'b1;
            sda_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            sda_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_m_r <= scl_i;
            sda_m_r <= sda_i;
            scl_s_r <= scl_m_r;
            sda_s_r <= sda_m_r;
            scl_d_r <= scl_s_r;
            sda_d_r <= sda_s_r;
        end
    end

    // Bus events from the settled levels
    wire scl_rise = scl_s_r & ~scl_d_r;
    wire scl_fall = ~scl_s_r & scl_d_r;
    wire bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
    wire bus_stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

    // Serial port state
    msa_pkg::msa_state_t state_r, state_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic [7:0] shreg_r, shreg_nxt;
    logic [1:0] byte_idx_r, byte_idx_nxt;
    logic rw_r, rw_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic [7:0] hi_r, hi_nxt;
    logic [15:0] tx_word_r, tx_word_nxt;
    logic tx_lo_r, tx_lo_nxt;
    logic nack_r, nack_nxt;
    logic mask_we, status_rd;

    // Register read selection; unmapped pointers read as zero
    wire [15:0] rd_word = (ptr_r == msa_pkg::REG_STATUS) ? limit_status_flags :
                          (ptr_r == msa_pkg::REG_MASK) ? alert_mask_enable :
                          (ptr_r == msa_pkg::REG_SHUNT) ? shunt_voltage_result : 16'h0000;
    wire byte_full = (bit_cnt_r == msa_pkg::BITS_PER_BYTE);
    wire addr_hit = (shreg_r[7:1] == DEV_ADDR);
    wire [1:0] byte_step = (byte_idx_r == msa_pkg::BYTE_LO) ? byte_idx_r : byte_idx_r + 2'h1;
    wire [3:0] tx_idx = {~tx_lo_r, ~bit_cnt_r[2:0]};

    // Byte framing, acknowledge and register pointer handling
    always_comb
    begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        shreg_nxt = shreg_r;
        byte_idx_nxt = byte_idx_r;
        rw_nxt = rw_r;
        ptr_nxt = ptr_r;
        hi_nxt = hi_r;
        tx_word_nxt = tx_word_r;
        tx_lo_nxt = tx_lo_r;
        nack_nxt = nack_r;
        mask_we = 1'b0;
        status_rd = 1'b0;
        if (bus_start)
        begin
            state_nxt = msa_pkg::ST_RX;
            bit_cnt_nxt = 4'h0;
            byte_idx_nxt = msa_pkg::BYTE_ADDR;
        end
        else if (bus_stop)
        begin
            state_nxt = msa_pkg::ST_IDLE;
        end
        else
        begin
            case (state_r)
                msa_pkg::ST_IDLE:
                begin
                    bit_cnt_nxt = 4'h0;
                end
                msa_pkg::ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shreg_nxt = {shreg_r[6:0], sda_s_r};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end
                    else if (scl_fall && byte_full)
                    begin
                        state_nxt = msa_pkg::ST_RX_ACK;
                        case (byte_idx_r)
                            msa_pkg::BYTE_ADDR:
                            begin
                                rw_nxt = shreg_r[0];
                                if (!addr_hit)
                                    state_nxt = msa_pkg::ST_IDLE;
                            end
                            msa_pkg::BYTE_PTR: ptr_nxt = shreg_r;
                            msa_pkg::BYTE_HI: hi_nxt = shreg_r;
                            default: mask_we = (ptr_r == msa_pkg::REG_MASK);
                        endcase
                    end
                end
                msa_pkg::ST_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_nxt = 4'h0;
                        byte_idx_nxt = byte_step;
                        tx_lo_nxt = 1'b0;
                        tx_word_nxt = rd_word;
                        state_nxt = (rw_r && byte_idx_r == msa_pkg::BYTE_ADDR) ?
                                    msa_pkg::ST_TX : msa_pkg::ST_RX;
                    end
                end
                msa_pkg::ST_TX:
                begin
                    // Count on SCL fall so a bit never moves while SCL is high
                    if (scl_fall && bit_cnt_r != 4'h7)
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    else if (scl_fall)
                    begin
                        state_nxt = msa_pkg::ST_TX_ACK;
                        // Whole word sent: status counts as read here
                        status_rd = tx_lo_r && (ptr_r == msa_pkg::REG_STATUS);
                    end
                end
                msa_pkg::ST_TX_ACK:
                begin
                    if (scl_rise)
                        nack_nxt = sda_s_r;
                    else if (scl_fall)
                    begin
                        bit_cnt_nxt = 4'h0;
                        state_nxt = nack_r ? msa_pkg::ST_IDLE : msa_pkg::ST_TX;
                        tx_lo_nxt = ~tx_lo_r;
                        // Next word is a fresh snapshot, so repeated reads stay current
                        if (tx_lo_r)
                            tx_word_nxt = rd_word;
                    end
                end
                default: state_nxt = msa_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= msa_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            shreg_r <= 8'h00;
            byte_idx_r <= msa_pkg::BYTE_ADDR;
            rw_r <= 1'b0;
            ptr_r <= 8'h00;
            hi_r <= 8'h00;
            tx_word_r <= 16'h0000;
            tx_lo_r <= 1'b0;
            nack_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shreg_r <= shreg_nxt;
            byte_idx_r <= byte_idx_nxt;
            rw_r <= rw_nxt;
            ptr_r <= ptr_nxt;
            hi_r <= hi_nxt;
            tx_word_r <= tx_word_nxt;
            tx_lo_r <= tx_lo_nxt;
            nack_r <= nack_nxt;
        end
    end

    // Open-drain data: pull low for acknowledge or a zero data bit
    assign sda_o = 1'b0;
    assign sda_oe = (state_r == msa_pkg::ST_RX_ACK) ||
                    (state_r == msa_pkg::ST_TX && !byte_full && !tx_word_r[tx_idx]);

    // Mask/enable register, bit 4 has no storage
    logic [15:0] mask_r;
    wire [15:0] mask_wdata = {hi_r, shreg_r} & 16'hFFEF;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            mask_r <= msa_pkg::MASK_RESET;
        else if (mask_we)
            mask_r <= mask_wdata;
    end
    assign alert_mask_enable = mask_r;

    // Shunt full scale doubles per gain step; code 11 is divide-by-8
    wire [15:0] fs_pos = msa_pkg::SHUNT_FS_UNITY << shunt_gain_select;
    wire signed [15:0] fs_neg = -$signed(fs_pos);
    // Clamping to the range leaves all sign bits equal to the top bit
    wire [15:0] shunt_fmt = ($signed(meas.shunt_raw) > $signed(fs_pos)) ? fs_pos :
                            ($signed(meas.shunt_raw) < fs_neg) ? fs_neg :
                            meas.shunt_raw;
    logic [15:0] shunt_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            shunt_r <= msa_pkg::SHUNT_RESET;
        else if (meas_done)
            shunt_r <= shunt_fmt;
    end
    assign shunt_voltage_result = shunt_r;

    // Limit comparisons on the latest results
    logic [15:0] flags_r, flags_nxt;
    logic [15:0] viol, hold;
    always_comb
    begin
        viol = 16'h0000;
        viol[15] = meas.bus_volt > limits.bus_over_warn;
        viol[14] = meas.bus_volt < limits.bus_under_warn;
        viol[13] = meas.power > limits.power_warn;
        viol[12] = $signed(shunt_r) > $signed(limits.shunt_pos_warn);
        viol[11] = $signed(shunt_r) < $signed(limits.shunt_neg_warn);
        viol[10] = meas.bus_volt > limits.bus_over_lim;
        viol[9] = meas.bus_volt < limits.bus_under_lim;
        viol[8] = meas.power > limits.power_lim;
        viol[7] = $signed(shunt_r) > $signed(limits.critical_pos_flag_pos);
        viol[6] = $signed(shunt_r) < $signed(limits.critical_pos_flag_neg);
    end

    // Latch option per flag group
    assign hold = {{5{latch_opt.warn}}, {3{latch_opt.limit}}, {2{latch_opt.critical_pos_flag}}, 6'h00};

    // Alert raised by any enabled, unmasked flag of bits 15 to 5; of the mask, only the alert enable clears a flag (the alert flag)
    wire alert_en = mask_r[msa_pkg::MASK_ALERT_EN];
    wire alert_req = alert_en & |(flags_r[15:5] & mask_r[15:5]);
    wire cfg_clr = cfg_write && cfg_mode != msa_pkg::MODE_POWER_DOWN &&
                   cfg_mode != msa_pkg::MODE_ADC_OFF;

    // Limit flags: live, or sticky until a status read when latched
    genvar gi;
    generate
        for (gi = msa_pkg::FLAG_CRITICAL_POS_FLAG_LOW; gi <= msa_pkg::FLAG_WARN_TOP; gi++)
        begin : g_lim
            assign flags_nxt[gi] = viol[gi] | (flags_r[gi] & hold[gi] & ~status_rd);
        end
    endgenerate
    // Event flags; a set in the clearing cycle wins
    assign flags_nxt[5] = meas_done | (flags_r[5] & ~(status_rd | cfg_clr | convert_trig));
    assign flags_nxt[4] = alert_req | (flags_r[4] & ~status_rd & alert_en);
    assign flags_nxt[3] = math_ovf | (flags_r[3] & ~status_rd);
    assign flags_nxt[2:0] = 3'h0;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flags_r <= msa_pkg::STATUS_RESET;
        else
            flags_r <= flags_nxt;
    end
    assign limit_status_flags = flags_r;

    // Watchdog pins; overflow drives none of them
    logic warn_pin_r, limit_pin_r, critical_pos_flag_pin_r;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            warn_pin_r <= 1'b0;
            limit_pin_r <= 1'b0;
            critical_pos_flag_pin_r <= 1'b0;
        end
        else
        begin
            warn_pin_r <= mask_r[msa_pkg::MASK_WARN_EN] & |flags_r[15:11];
            limit_pin_r <= mask_r[msa_pkg::MASK_LIMIT_EN] & |flags_r[10:8];
            critical_pos_flag_pin_r <= mask_r[msa_pkg::MASK_CRITICAL_POS_FLAG_EN] & |flags_r[7:6];
        end
    end
    assign warning_pin = warn_pin_r;
    assign limit_pin = limit_pin_r;
    assign critical_pin = critical_pos_flag_pin_r;

    // Alert pin pulled low while the alert flag stands
    assign alert_o = 1'b0;
    assign alert_oe = flags_r[msa_pkg::FLAG_ALERT];
endmodule

// ### msa_pkg.sv
// Constants, field positions and carrier types of the status and alert logic
package msa_pkg;
    // Register pointer values seen on the serial port
    localparam logic [7:0] REG_STATUS = 8'h01;
    localparam logic [7:0] REG_MASK = 8'h02;
    localparam logic [7:0] REG_SHUNT = 8'h03;
    // Values after reset
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] SHUNT_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // Status flag positions
    localparam int FLAG_WARN_TOP = 15;
    localparam int FLAG_WARN_LOW = 11;
    localparam int FLAG_LIMIT_TOP = 10;
    localparam int FLAG_LIMIT_LOW = 8;
    localparam int FLAG_CRITICAL_POS_FLAG_TOP = 7;
    localparam int FLAG_CRITICAL_POS_FLAG_LOW = 6;
    localparam int FLAG_CONV = 5;
    localparam int FLAG_ALERT = 4;
    localparam int FLAG_OVF = 3;
    // Mask register field positions
    localparam int MASK_LOW = 5;
    localparam int MASK_ALERT_EN = 3;
    localparam int MASK_CRITICAL_POS_FLAG_EN = 2;
    localparam int MASK_LIMIT_EN = 1;
    localparam int MASK_WARN_EN = 0;
    // Shunt full scale at unity gain, in 10 uV counts; doubles per gain step
    localparam logic [15:0] SHUNT_FS_UNITY = 16'h0FA0;
    localparam logic [1:0] GAIN_DIV8 = 2'h3;
    // Operating modes that do not clear the conversion flag on a config write
    localparam logic [2:0] MODE_POWER_DOWN = 3'h0;
    localparam logic [2:0] MODE_ADC_OFF = 3'h4;
    // Serial port framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] BYTE_ADDR = 2'h0;
    localparam logic [1:0] BYTE_PTR = 2'h1;
    localparam logic [1:0] BYTE_HI = 2'h2;
    localparam logic [1:0] BYTE_LO = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX = 3'h1,
        ST_RX_ACK = 3'h3,
        ST_TX = 3'h2,
        ST_TX_ACK = 3'h6
    } msa_state_t;

    // Results from the converters and arithmetic
    typedef struct packed {
        logic [15:0] bus_volt;
        logic [15:0] power;
        logic signed [15:0] shunt_raw;
    } msa_meas_t;

    // Limit values from the limit registers
    typedef struct packed {
        logic [15:0] bus_over_warn;
        logic [15:0] bus_under_warn;
        logic [15:0] power_warn;
        logic signed [15:0] shunt_pos_warn;
        logic signed [15:0] shunt_neg_warn;
        logic [15:0] bus_over_lim;
        logic [15:0] bus_under_lim;
        logic [15:0] power_lim;
        logic signed [15:0] critical_pos_flag_pos;
        logic signed [15:0] critical_pos_flag_neg;
    } msa_limits_t;

    // Latch options per flag group
    typedef struct packed {
        logic warn;
        logic limit;
        logic critical_pos_flag;
    } msa_latch_t;
endpackage

// ### msa_host_model.sv
// Host controller model for the serial register port
`timescale 1ns/10ps
module msa_host_model (
    input wire logic clk, // System clock
    input wire logic sda_in, // Resolved data line
    output logic scl_o, // Serial clock
    output logic sda_low_o // High pulls data low
);
    // Idle bus: clock high, data left to the pull-up
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic wt(input int k);
        repeat (k) @(negedge clk);
    endtask
    // Start or repeated start; 8-clock phases clear the 4-clock minimum
    task automatic start_c();
        sda_low_o = 1'b0;
        wt(4);
        scl_o = 1'b1;
        wt(8);
        sda_low_o = 1'b1;
        wt(8);
        scl_o = 1'b0;
    endtask
    task automatic stop_c();
        wt(4);
        sda_low_o = 1'b1;
        wt(4);
        scl_o = 1'b1;
        wt(8);
        sda_low_o = 1'b0;
        wt(8);
    endtask
    // Eight bits MSB first, then the acknowledge slot; ones release the line
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        rx = tx;
        for (int i = 8; i >= 0; i--)
        begin
            wt(4);
            sda_low_o = ~tx[i];
            wt(4);
            scl_o = 1'b1;
            wt(8);
            rx[i] = sda_in;
            scl_o = 1'b0;
        end
    endtask
    // Pointer write, then MSB and LSB out, or repeated start and two bytes in
    task automatic acc(input logic rd, input logic [6:0] a, input logic [7:0] p,
        input logic [15:0] din, output logic [15:0] dout, output logic nak);
        logic [8:0] r0, r1, r2, hi, lo;
        r2 = 9'h000;
        start_c();
        xfer({a, 2'b01}, r0);
        xfer({p, 1'b1}, r1);
        if (rd)
        begin
            start_c();
            xfer({a, 2'b11}, r2);
        end
        xfer(rd ? 9'h1FE : {din[15:8], 1'b1}, hi);
        xfer(rd ? 9'h1FF : {din[7:0], 1'b1}, lo);
        stop_c();
        dout = {hi[8:1], lo[8:1]};
        nak = r0[0] | r1[0] | r2[0] | (!rd & (hi[0] | lo[0]));
    endtask
endmodule

// ### msa_top_chk.sv
// Assertions on flags, alert enable, watchdog pins and shunt format
`timescale 1ns/10ps
module msa_top_chk (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic warning_pin, // Warning out
    input wire logic limit_pin, // Over-limit out
    input wire logic critical_pin, // Critical out
    input wire logic meas_done, // Cycle done
    input wire logic math_ovf, // Overflow
    input wire logic [1:0] shunt_gain_select, // Gain code
    input wire logic cfg_write, // Config write
    input wire logic [2:0] cfg_mode, // Its mode
    input wire logic convert_trig, // Single shot
    input wire logic [15:0] alert_mask_enable, // Mask reg
    input wire logic [15:0] shunt_voltage_result, // Shunt reg
    input wire logic [15:0] limit_status_flags // Status reg
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic [1:0] gain_q;
    logic [3:0] sgn;
    logic conv_clr;
    // Gain at the last shunt load sets how many sign copies exist
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            gain_q <= 2'h0;
        else if (meas_done)
            gain_q <= shunt_gain_select;
    end
    // Idle modes must not count as a clearing config write
    assign sgn = {4{shunt_voltage_result[15]}};
    assign conv_clr = convert_trig | (cfg_write & (cfg_mode != msa_pkg::MODE_POWER_DOWN)
        & (cfg_mode != msa_pkg::MODE_ADC_OFF));
    property p_warn_pin;
        1 |=> warning_pin == $past(alert_mask_enable[0] & (|limit_status_flags[15:11]));
    endproperty
    a_warn_pin: assert property (p_warn_pin) else $error("warning pin wrong");
    property p_limit_pin;
        ##1 limit_pin |-> $past(alert_mask_enable[1]) && $past(|limit_status_flags[10:8]);
    endproperty
    a_limit_pin: assert property (p_limit_pin) else $error("limit pin wrong");
    property p_critical_pos_flag_pin;
        alert_mask_enable[2] && (|limit_status_flags[7:6]) |=> critical_pin;
    endproperty
    a_critical_pos_flag_pin: assert property (p_critical_pos_flag_pin) else $error("critical pin low");
    property p_alert_off;
        !alert_mask_enable[3] |=> !limit_status_flags[4];
    endproperty
    a_alert_off: assert property (p_alert_off) else $error("alert flag kept");
    property p_alert_on;
        alert_mask_enable[3] && (|(limit_status_flags[15:5] & alert_mask_enable[15:5]))
            |=> limit_status_flags[4];
    endproperty
    a_alert_on: assert property (p_alert_on) else $error("alert flag missing");
    property p_sign;
        (shunt_voltage_result[15:12] >> gain_q) == (sgn >> gain_q);
    endproperty
    a_sign: assert property (p_sign) else $error("shunt sign copies differ");
    property p_ovf;
        math_ovf |=> limit_status_flags[3];
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag missing");
    property p_conv_clr;
        conv_clr && !meas_done |=> !limit_status_flags[5];
    endproperty
    a_conv_clr: assert property (p_conv_clr) else $error("conversion flag kept");
    c_alert: cover property (limit_status_flags[4]);
    c_pins: cover property (warning_pin && limit_pin && critical_pin);
    c_trig: cover property (convert_trig ##1 !limit_status_flags[5]);
endmodule
bind msa_top msa_top_chk chk_u (.clk(clk), .rst_n(rst_n), .warning_pin(warning_pin),
    .limit_pin(limit_pin), .critical_pin(critical_pin), .meas_done(meas_done),
    .math_ovf(math_ovf), .shunt_gain_select(shunt_gain_select), .cfg_write(cfg_write),
    .cfg_mode(cfg_mode), .convert_trig(convert_trig), .alert_mask_enable(alert_mask_enable),
    .shunt_voltage_result(shunt_voltage_result), .limit_status_flags(limit_status_flags));

// ### msa_tb_top.sv
// Self-checking bench for the status, alert and shunt result logic
`timescale 1ns/10ps
module msa_tb_top;
    localparam logic [6:0] DEV = 7'h2A; // Arbitrary device address
    // Positive full scale per gain code, 11 down to 00
    localparam logic [63:0] FS_TAB = 64'h7D00_3E80_1F40_0FA0;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic meas_done = 1'b0;
    logic math_ovf = 1'b0;
    logic cfg_write = 1'b0;
    logic convert_trig = 1'b0;
    logic [2:0] cfg_mode = 3'h0;
    logic [1:0] gain = msa_pkg::GAIN_DIV8;
    msa_pkg::msa_meas_t meas = {16'h004B, 16'h0032, 16'h0000};
    msa_pkg::msa_limits_t limits = {16'h0064, 16'h0032, 16'h0064, 16'h0064, 16'hFF9C,
        16'h00C8, 16'h0014, 16'h00C8, 16'h00C8, 16'hFF38};
    msa_pkg::msa_latch_t latch_opt = 3'h0;
    logic scl, host_low, sda_o, sda_oe, alert_o, alert_oe, warn_p, lim_p, critical_pos_flag_p, n;
    logic [15:0] mask_q, shunt_q, flags_q, e, v;
    wire sda_w;
    int fail_count = 0;
    int samples_checked = 0;
    // Open-drain data line with its pull-up
    assign sda_w = ~(host_low | (sda_oe & ~sda_o));
    always #4 clk = ~clk;
    msa_top #(.DEV_ADDR(DEV)) dut_u (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe(sda_oe), .alert_o(alert_o), .alert_oe(alert_oe),
        .warning_pin(warn_p), .limit_pin(lim_p), .critical_pin(critical_pos_flag_p), .meas(meas),
        .meas_done(meas_done), .math_ovf(math_ovf), .limits(limits), .latch_opt(latch_opt),
        .shunt_gain_select(gain), .cfg_write(cfg_write), .cfg_mode(cfg_mode),
        .convert_trig(convert_trig), .alert_mask_enable(mask_q),
        .shunt_voltage_result(shunt_q), .limit_status_flags(flags_q));
    msa_host_model host_u (.clk(clk), .sda_in(sda_w), .scl_o(scl), .sda_low_o(host_low));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    // Register access; every access must be acknowledged
    task automatic w(input logic [7:0] p, input logic [15:0] d);
        host_u.acc(1'b0, DEV, p, d, v, n);
        chk({15'h0, n}, 16'h0000);
    endtask
    task automatic r(input logic [7:0] p, input logic [15:0] x);
        host_u.acc(1'b1, DEV, p, 16'h0000, v, n);
        chk({15'h0, n}, 16'h0000);
        chk(v, x);
    endtask
    // Flags and the three pins once a stimulus has settled
    task automatic fl(input logic [15:0] f, input logic [2:0] pins);
        host_u.wt(3);
        chk(flags_q, f);
        chk({13'h0, warn_p, lim_p, critical_pos_flag_p}, {13'h0, pins});
    endtask
    initial
    begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        fl(msa_pkg::STATUS_RESET, 3'h0);
        r(msa_pkg::REG_STATUS, msa_pkg::STATUS_RESET);
        r(msa_pkg::REG_MASK, msa_pkg::MASK_RESET);
        r(msa_pkg::REG_SHUNT, msa_pkg::SHUNT_RESET);
        r(8'h05, 16'h0000);
        // Wrong device address is ignored
        host_u.acc(1'b0, 7'h15, msa_pkg::REG_MASK, 16'hFFFF, v, n);
        chk({15'h0, n}, 16'h0001);
        chk(mask_q, msa_pkg::MASK_RESET);
        meas = {16'h012C, 16'h012C, 16'h012C};
        pulse(meas_done);
        fl(16'hB5A0, 3'h0);
        r(msa_pkg::REG_STATUS, 16'hB5A0);
        fl(16'hB580, 3'h0);
        w(msa_pkg::REG_MASK, 16'h0007);
        meas = {16'h000A, 16'h0000, 16'hFED4};
        pulse(meas_done);
        fl(16'h4A60, 3'h7);
        meas = {16'h004B, 16'h0032, 16'h0000};
        pulse(meas_done);
        fl(16'h0020, 3'h0);
        pulse(math_ovf);
        fl(16'h0028, 3'h0);
        // Alert needs both its enable and an unmasked flag
        w(msa_pkg::REG_MASK, 16'h0008);
        fl(16'h0028, 3'h0);
        w(msa_pkg::REG_MASK, 16'h0028);
        fl(16'h0038, 3'h0);
        chk({15'h0, alert_oe}, 16'h0001);
        chk({15'h0, alert_o}, 16'h0000);
        w(msa_pkg::REG_MASK, 16'h0030);
        r(msa_pkg::REG_MASK, 16'h0020);
        fl(16'h0028, 3'h0);
        w(msa_pkg::REG_MASK, 16'h0028);
        pulse(convert_trig);
        fl(16'h0018, 3'h0);
        r(msa_pkg::REG_STATUS, 16'h0018);
        fl(16'h0000, 3'h0);
        for (int m = 0; m < 8; m++)
        begin
            cfg_mode = 3'(m);
            pulse(meas_done);
            pulse(cfg_write);
            host_u.wt(2);
            e = {15'h0, cfg_mode == msa_pkg::MODE_POWER_DOWN || cfg_mode == msa_pkg::MODE_ADC_OFF};
            chk({15'h0, flags_q[5]}, e);
        end
        // Full-scale clamp in both directions and minus one, every gain code
        for (int g = 0; g < 4; g++)
        begin
            gain = 2'(g);
            for (int k = 0; k < 3; k++)
            begin
                meas.shunt_raw = k == 0 ? 16'h7FFF : k == 1 ? 16'h8001 : 16'hFFFF;
                e = FS_TAB[16 * g +: 16];
                e = k == 0 ? e : k == 1 ? -e : 16'hFFFF;
                pulse(meas_done);
                host_u.wt(2);
                chk(shunt_q, e);
            end
        end
        r(msa_pkg::REG_SHUNT, 16'hFFFF);
        // Latched warning survives the end of its violation
        latch_opt = 3'h4;
        meas.bus_volt = 16'h012C;
        pulse(meas_done);
        meas.bus_volt = 16'h004B;
        pulse(meas_done);
        fl(16'h8030, 3'h0);
        r(msa_pkg::REG_STATUS, 16'h8030);
        // Alert saw the unmasked conversion flag at the read edge, so it sets again
        fl(16'h0010, 3'h0);
        r(msa_pkg::REG_STATUS, 16'h0010);
        fl(16'h0000, 3'h0);
        end_sim();
    end
    // Watchdog: the sequence needs about 12000 clocks
    initial
    begin
        repeat (60000) @(posedge clk);
        fail_count++;
        end_sim();
    end
endmodule
